// file: sync_burst_sram_cycle_decode.v
// cycle decoder and data bus control for a flow-through burst sram
`include "sram_cycle_regs.vh"

module sync_burst_sram_cycle_decode
#(
    parameter ADDR_W       = `ADDR_WIDTH,
    parameter SLEEP_CYCLES = `SLEEP_CYCLES
)
(
    // clock and reset
    input  wire                    core_clk,
    input  wire                    rst,
    // synchronous command inputs
    input  wire                    chip_select_first_n,
    input  wire                    chip_select_second_p,
    input  wire                    chip_select_third_n,
    input  wire                    advance_or_load,
    input  wire                    write_enable_n,
    input  wire [`LANE_COUNT-1:0]  byte_lane_write_n,
    input  wire                    clock_hold_n,
    input  wire [ADDR_W-1:0]       address,
    // asynchronous and static inputs
    input  wire                    sleep_request,
    input  wire                    output_enable_n,
    input  wire                    burst_mode,
    // common data bus, split into in, out and enable
    input  wire [`DATA_BITS-1:0]   data_io_in,
    output wire [`DATA_BITS-1:0]   data_io_out,
    output wire                    data_io_oe_n,
    input  wire [`PARITY_BITS-1:0] parity_io_in,
    output wire [`PARITY_BITS-1:0] parity_io_out,
    output wire                    parity_io_oe_n,
    // status
    output wire [`OP_W-1:0]        cycle_state,
    output wire                    sleeping
);

    localparam WORD_W = `LANE_COUNT * `LANE_BITS;

    // ------------------------------------------------------------
    // state and wires
    // ------------------------------------------------------------
    reg  [`OP_W-1:0]         op_ff;
    reg  [`OP_W-1:0]         nxt_op;
    reg  [ADDR_W-1:0]        addr_hi_ff;
    reg  [ADDR_W-1:0]        nxt_addr_hi;
    reg  [WORD_W-1:0]        rd_data_ff;
    reg                      sleep_meta_ff;
    reg                      sleep_sync_ff;
    reg                      mode_meta_ff;
    reg                      mode_sync_ff;
    reg                      asleep_ff;
    reg  [`SLEEP_CNT_W-1:0]  sleep_cnt_ff;
    reg                      load;
    reg                      advance;
    reg                      wr_beat;
    wire                     quiet;
    wire                     step_en;
    wire                     selected;
    wire [`BURST_BITS-1:0]   cur_low;
    wire [`BURST_BITS-1:0]   nxt_low;
    wire [ADDR_W-1:0]        cur_addr;
    wire [ADDR_W-1:0]        nxt_addr;
    wire [`LANE_COUNT-1:0]   wr_lane_en;
    wire [WORD_W-1:0]        wr_word;
    wire [WORD_W-1:0]        rd_word;
    wire                     drive;

    // ------------------------------------------------------------
    // lane packing
    // ------------------------------------------------------------
    // a lane is eight data bits with its parity bit on top
    function [WORD_W-1:0] pack_lanes;
        input [`DATA_BITS-1:0]   d;
        input [`PARITY_BITS-1:0] p;
        integer                  i;
        begin
            pack_lanes = {WORD_W{1'b0}};
            for (i = 0; i < `LANE_COUNT; i = i + 1)
                pack_lanes[i*`LANE_BITS +: `LANE_BITS] = {p[i], d[i*8 +: 8]};
        end
    endfunction

    // replace the written lanes of a read word, for same-edge bypass
    function [WORD_W-1:0] merge_lanes;
        input [WORD_W-1:0]      old_w;
        input [WORD_W-1:0]      new_w;
        input [`LANE_COUNT-1:0] en;
        integer                 i;
        begin
            merge_lanes = old_w;
            for (i = 0; i < `LANE_COUNT; i = i + 1)
                if (en[i])
                    merge_lanes[i*`LANE_BITS +: `LANE_BITS] =
                        new_w[i*`LANE_BITS +: `LANE_BITS];
        end
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // sleep is asynchronous and mode is a strap; both cross two stages
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            sleep_meta_ff <= 1'b0;
            sleep_sync_ff <= 1'b0;
            mode_meta_ff  <= 1'b1;
            mode_sync_ff  <= 1'b1;
        end
        else
        begin
            sleep_meta_ff <= sleep_request;
            sleep_sync_ff <= sleep_meta_ff;
            mode_meta_ff  <= burst_mode;
            mode_sync_ff  <= mode_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // sleep entry and exit
    // ------------------------------------------------------------
    // entry and exit each take SLEEP_CYCLES of steady request; a short
    // blip restarts the count rather than toggling the mode
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            asleep_ff    <= 1'b0;
            sleep_cnt_ff <= 2'h0;
        end
        else if (sleep_sync_ff != asleep_ff)
        begin
            if (sleep_cnt_ff == SLEEP_CYCLES[`SLEEP_CNT_W-1:0] - 2'h1)
            begin
                asleep_ff    <= sleep_sync_ff;
                sleep_cnt_ff <= 2'h0;
            end
            else
            begin
                sleep_cnt_ff <= sleep_cnt_ff + 2'h1;
            end
        end
        else
        begin
            sleep_cnt_ff <= 2'h0;
        end
    end

    // during request, sleep and recovery nothing is sampled
    assign quiet   = sleep_sync_ff | asleep_ff;
    // a held edge changes nothing except through the sleep path, which can still force a deselect
    assign step_en = ~quiet & ~clock_hold_n;

    // ------------------------------------------------------------
    // cycle decode
    // ------------------------------------------------------------
    assign selected = ~chip_select_first_n & chip_select_second_p & ~chip_select_third_n;

    // decide the cycle that starts at this edge
    always @*
    begin
        nxt_op      = op_ff;
        nxt_addr_hi = addr_hi_ff;
        load        = 1'b0;
        advance     = 1'b0;
        wr_beat     = 1'b0;
        if (step_en)
        begin
            // the edge closing a write cycle is its data beat
            wr_beat = (op_ff == `OP_WRITE);
            if (!advance_or_load)
            begin
                if (!selected)
                begin
                    nxt_op = `OP_DESELECT;
                end
                else if (write_enable_n)
                begin
                    nxt_op      = `OP_READ;
                    nxt_addr_hi = address;
                    load        = 1'b1;
                end
                else
                begin
                    nxt_op      = `OP_WRITE;
                    nxt_addr_hi = address;
                    load        = 1'b1;
                end
            end
            else if (op_ff != `OP_DESELECT)
            begin
                // selects and write strobe are not looked at here
                advance = 1'b1;
            end
        end
        if (quiet)
            nxt_op = `OP_DESELECT;
    end

    // cycle state and upper address
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            op_ff      <= `OP_DESELECT;
            addr_hi_ff <= {ADDR_W{1'b0}};
        end
        else
        begin
            op_ff      <= nxt_op;
            addr_hi_ff <= nxt_addr_hi;
        end
    end

    // ------------------------------------------------------------
    // burst address
    // ------------------------------------------------------------
    burst_counter u_burst
    (
        .core_clk   (core_clk),
        .rst        (rst),
        .step_en    (step_en),
        .load       (load),
        .advance    (advance),
        .start_low  (address[`BURST_BITS-1:0]),
        .interleave (mode_sync_ff),
        .cur_low    (cur_low),
        .nxt_low    (nxt_low)
    );

    assign cur_addr = {addr_hi_ff[ADDR_W-1:`BURST_BITS], cur_low};
    assign nxt_addr = {nxt_addr_hi[ADDR_W-1:`BURST_BITS], nxt_low};

    // ------------------------------------------------------------
    // write path
    // ------------------------------------------------------------
    // each lane follows its own select, so all-high writes nothing
    // but the burst still advances
    assign wr_lane_en = {`LANE_COUNT{wr_beat}} & ~byte_lane_write_n;
    assign wr_word    = pack_lanes(data_io_in, parity_io_in);

    sram_lane_array
    #(
        .ADDR_W (ADDR_W),
        .LANES  (`LANE_COUNT),
        .LANE_W (`LANE_BITS)
    )
    u_array
    (
        .core_clk   (core_clk),
        .wr_addr    (cur_addr),
        .wr_lane_en (wr_lane_en),
        .wr_word    (wr_word),
        .rd_addr    (nxt_addr),
        .rd_word    (rd_word)
    );

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // the array is read for the coming cycle so data is ready just
    // after the edge; a write landing on that address is bypassed so
    // a read right behind a write sees the new bytes
    always @(posedge core_clk)
    begin
        if (rst)
            rd_data_ff <= {WORD_W{1'b0}};
        else if (step_en)
        begin
            if (nxt_addr == cur_addr)
                rd_data_ff <= merge_lanes(rd_word, wr_word, wr_lane_en);
            else
                rd_data_ff <= rd_word;
        end
    end

    // ------------------------------------------------------------
    // output drivers
    // ------------------------------------------------------------
    // output enable is never registered; it only gates a read cycle
    assign drive = (op_ff == `OP_READ) & ~quiet & ~output_enable_n;

    assign data_io_oe_n   = ~drive;
    assign parity_io_oe_n = ~drive;

    genvar g;
    generate
        for (g = 0; g < `LANE_COUNT; g = g + 1)
        begin : g_unpack
            assign data_io_out[g*8 +: 8] = rd_data_ff[g*`LANE_BITS +: 8];
            assign parity_io_out[g]      = rd_data_ff[g*`LANE_BITS + 8];
        end
    endgenerate

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    assign cycle_state = op_ff;
    assign sleeping    = asleep_ff;

endmodule

// file: sram_cycle_regs.vh
// constants for the synchronous burst sram cycle decoder
`ifndef SRAM_CYCLE_REGS_VH
`define SRAM_CYCLE_REGS_VH

// ----------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------
`define ADDR_WIDTH      21
`define LANE_COUNT      4
`define LANE_BITS       9
`define DATA_BITS       32
`define PARITY_BITS     4
`define BURST_BITS      2

// ----------------------------------------------------------------
// cycle states held between edges
// ----------------------------------------------------------------
`define OP_W            2
`define OP_DESELECT     2'h0
`define OP_READ         2'h1
`define OP_WRITE        2'h2

// ----------------------------------------------------------------
// sleep entry and exit timing
// ----------------------------------------------------------------
`define CORE_CLK_HZ     20000000
`define SLEEP_CYCLES    2
`define SLEEP_CNT_W     2

`endif

// file: burst_counter.v
// two-bit burst address sequencer, linear or interleaved order
`include "sram_cycle_regs.vh"

module burst_counter
(
    // clock and reset
    input  wire                   core_clk,
    input  wire                   rst,
    // control from the cycle decoder
    input  wire                   step_en,
    input  wire                   load,
    input  wire                   advance,
    input  wire [`BURST_BITS-1:0] start_low,
    input  wire                   interleave,
    // address low bits
    output wire [`BURST_BITS-1:0] cur_low,
    output reg  [`BURST_BITS-1:0] nxt_low
);

    reg  [`BURST_BITS-1:0] base_ff;
    reg  [`BURST_BITS-1:0] beat_ff;
    wire [`BURST_BITS-1:0] beat_inc;

    // ------------------------------------------------------------
    // burst order
    // ------------------------------------------------------------
    // wraps after four beats in both orders
    function [`BURST_BITS-1:0] order;
        input [`BURST_BITS-1:0] base;
        input [`BURST_BITS-1:0] beat;
        input                   ilv;
        begin
            if (ilv)
                order = base ^ beat;
            else
                order = base + beat;
        end
    endfunction

    assign beat_inc = beat_ff + 2'h1;
    assign cur_low  = order(base_ff, beat_ff, interleave);

    // next low bits, also used for the early array read
    always @*
    begin
        if (step_en && load)
            nxt_low = start_low;
        else if (step_en && advance)
            nxt_low = order(base_ff, beat_inc, interleave);
        else
            nxt_low = cur_low;
    end

    // base and beat registers
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            base_ff <= 2'h0;
            beat_ff <= 2'h0;
        end
        else if (step_en && load)
        begin
            base_ff <= start_low;
            beat_ff <= 2'h0;
        end
        else if (step_en && advance)
        begin
            beat_ff <= beat_inc;
        end
    end

endmodule

// file: sram_lane_array.v
// flip-flop storage array with independent byte-lane writes
`include "sram_cycle_regs.vh"

module sram_lane_array
#(
    parameter ADDR_W = `ADDR_WIDTH,
    parameter LANES  = `LANE_COUNT,
    parameter LANE_W = `LANE_BITS
)
(
    // clock
    input  wire                      core_clk,
    // write port
    input  wire [ADDR_W-1:0]         wr_addr,
    input  wire [LANES-1:0]          wr_lane_en,
    input  wire [LANES*LANE_W-1:0]   wr_word,
    // read port
    input  wire [ADDR_W-1:0]         rd_addr,
    output wire [LANES*LANE_W-1:0]   rd_word
);

    localparam DEPTH = 1 << ADDR_W;

    reg [LANES*LANE_W-1:0] mem_ff [0:DEPTH-1];
    integer                k;

    // each lane stores only when its own enable is set
    always @(posedge core_clk)
    begin
        for (k = 0; k < LANES; k = k + 1)
        begin
            if (wr_lane_en[k])
                mem_ff[wr_addr][k*LANE_W +: LANE_W] <= wr_word[k*LANE_W +: LANE_W];
        end
    end

    assign rd_word = mem_ff[rd_addr];

endmodule

// file: sync_burst_sram_cycle_decode_checker.sv
// port assertions for the burst sram cycle decoder
`include "sram_cycle_regs.vh"
module sync_burst_sram_cycle_decode_checker
(
    // clock and reset
    input wire                  core_clk,
    input wire                  rst,
    // commands
    input wire                  chip_select_first_n,
    input wire                  chip_select_second_p,
    input wire                  chip_select_third_n,
    input wire                  advance_or_load,
    input wire                  write_enable_n,
    input wire                  clock_hold_n,
    input wire                  sleep_request,
    input wire                  output_enable_n,
    // outputs
    input wire [`DATA_BITS-1:0] data_io_out,
    input wire                  data_io_oe_n,
    input wire                  parity_io_oe_n,
    input wire [`OP_W-1:0]      cycle_state,
    input wire                  sleeping
);
    timeunit 1ns;
    timeprecision 1ps;
    reg  [2:0] req_hist_ff;
    wire       calm;
    wire       sel_on;
    wire       take;
    // sleep passes two sync flops, so keep three edges of history
    always @(posedge core_clk)
    begin
        req_hist_ff <= {req_hist_ff[1:0], sleep_request};
    end
    // an edge that the decoder must act on
    assign calm   = !sleeping && !sleep_request && (req_hist_ff == 3'h0);
    assign sel_on = !chip_select_first_n && chip_select_second_p && !chip_select_third_n;
    assign take   = !clock_hold_n && calm;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_deselect_tristate: assert property (cycle_state == `OP_DESELECT |-> data_io_oe_n && parity_io_oe_n)
        else $error("bus driven while deselected");
    a_write_tristate: assert property (cycle_state == `OP_WRITE |-> data_io_oe_n && parity_io_oe_n)
        else $error("bus driven during write");
    a_read_drives: assert property (cycle_state == `OP_READ && !output_enable_n |-> !data_io_oe_n && !parity_io_oe_n)
        else $error("read not driven");
    a_dummy_quiet: assert property (output_enable_n |-> data_io_oe_n && parity_io_oe_n)
        else $error("driven with output enable off");
    a_stall_holds: assert property (clock_hold_n && calm |=> $stable(cycle_state) && $stable(data_io_out))
        else $error("held edge changed state");
    a_read_load: assert property (take && !advance_or_load && sel_on && write_enable_n |=> cycle_state == `OP_READ)
        else $error("read not started");
    a_write_load: assert property (take && !advance_or_load && sel_on && !write_enable_n |=> cycle_state == `OP_WRITE)
        else $error("write not started");
    a_load_deselect: assert property (take && !advance_or_load && !sel_on |=> cycle_state == `OP_DESELECT)
        else $error("deselect not taken");
    a_burst_kept: assert property (take && advance_or_load |=> $stable(cycle_state))
        else $error("burst type changed");
    a_sleep_tristate: assert property (sleeping |-> data_io_oe_n && parity_io_oe_n)
        else $error("bus driven asleep");
    a_sleep_entry: assert property (sleep_request [*6] |-> sleeping)
        else $error("sleep entry late");
endmodule

bind sync_burst_sram_cycle_decode sync_burst_sram_cycle_decode_checker chk
(
    .core_clk, .rst, .chip_select_first_n, .chip_select_second_p, .chip_select_third_n,
    .advance_or_load, .write_enable_n, .clock_hold_n, .sleep_request, .output_enable_n,
    .data_io_out, .data_io_oe_n, .parity_io_oe_n, .cycle_state, .sleeping
);

// file: sram_controller_model.sv
// memory controller stand-in: commands, sleep and write data
module sram_controller_model
#(
    parameter AW = 4
)
(
    // command lines
    output logic          chip_select_first_n,
    output logic          chip_select_second_p,
    output logic          chip_select_third_n,
    output logic          advance_or_load,
    output logic          write_enable_n,
    output logic [3:0]    byte_lane_write_n,
    output logic          clock_hold_n,
    output logic [AW-1:0] address,
    output logic          sleep_request,
    // write data toward the shared bus
    output logic [31:0]   bus_data,
    output logic [3:0]    bus_parity
);
    timeunit 1ns;
    timeprecision 1ps;
    // one beat; a released bus toggles so stale data never looks valid
    task drive(input logic [2:0] sel, input logic adv, we_n, hold, input logic [3:0] ln,
               input logic [AW-1:0] a, input logic [35:0] wd, input logic wr);
        {chip_select_first_n, chip_select_second_p, chip_select_third_n} = sel;
        advance_or_load = adv;
        write_enable_n = we_n;
        clock_hold_n = hold;
        byte_lane_write_n = ln;
        address = a;
        {bus_parity, bus_data} = wr ? wd : ~{bus_parity, bus_data};
    endtask
    // callers deselect before sleep and keep selects off on wake
    task sleep_pin(input logic on);
        sleep_request = on;
    endtask
    // start deselected and awake
    initial
    begin
        sleep_request = 0;
        {bus_parity, bus_data} = 36'h0;
        drive(3'h5, 0, 1, 0, 4'hf, '0, 36'h0, 0);
    end
endmodule

// file: test_sync_burst_sram_cycle_decode.sv
// self-checking bench for the burst sram cycle decoder
module test_sync_burst_sram_cycle_decode;
    timeunit 1ns;
    timeprecision 1ps;
    localparam AW = 4;
    localparam ON = 3'h2;
    localparam OFF = 3'h5;
    logic              core_clk, rst, output_enable_n, burst_mode;
    wire               chip_select_first_n, chip_select_second_p, chip_select_third_n;
    wire               advance_or_load, write_enable_n, clock_hold_n, sleep_request;
    wire [3:0]         byte_lane_write_n, bus_parity, parity_io_in, parity_io_out;
    wire [AW-1:0]      address;
    wire [31:0]        bus_data, data_io_in, data_io_out;
    wire [1:0]         cycle_state;
    wire               data_io_oe_n, parity_io_oe_n, sleeping;
    logic [35:0]       ref_mem [16];
    logic [35:0]       exp_rd, wd, c_wd;
    logic [AW-1:0]     base, wa, c_a;
    logic [3:0]        c_ln;
    logic [2:0]        c_sel;
    logic              c_adv, c_we, c_hold, pend;
    int                failures, comparisons, seed, st, bt, i, m;
    // the wire: the device wins only while it drives
    assign data_io_in = data_io_oe_n ? bus_data : data_io_out;
    assign parity_io_in = parity_io_oe_n ? bus_parity : parity_io_out;
    sync_burst_sram_cycle_decode #(.ADDR_W(AW)) dut
    (
        .core_clk, .rst, .chip_select_first_n, .chip_select_second_p, .chip_select_third_n,
        .advance_or_load, .write_enable_n, .byte_lane_write_n, .clock_hold_n, .address,
        .sleep_request, .output_enable_n, .burst_mode, .data_io_in, .data_io_out,
        .data_io_oe_n, .parity_io_in, .parity_io_out, .parity_io_oe_n, .cycle_state, .sleeping
    );
    sram_controller_model #(.AW(AW)) ctl
    (
        .chip_select_first_n, .chip_select_second_p, .chip_select_third_n, .advance_or_load,
        .write_enable_n, .byte_lane_write_n, .clock_hold_n, .address, .sleep_request,
        .bus_data, .bus_parity
    );
    // 20 MHz clock
    initial
    begin
        core_clk = 0;
        forever #25 core_clk = ~core_clk;
    end
    task check(input logic [35:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // model the edge that took the last command, compare, then drive the next
    task step(input logic [2:0] sel, input logic adv, we, hold, input logic [3:0] ln,
              input logic [AW-1:0] a);
        logic [1:0] lo;
        @(posedge core_clk);
        #2;
        if (!c_hold)
        begin
            for (int k = 0; k < 4; k++)
                if (pend && !c_ln[k])
                    {ref_mem[wa][32+k], ref_mem[wa][8*k+:8]} = {c_wd[32+k], c_wd[8*k+:8]};
            if (!c_adv)
            begin
                st = (c_sel != ON) ? 0 : (c_we ? 1 : 2);
                base = c_a;
                bt = 0;
            end
            else if (st != 0)
                bt++;
            lo = burst_mode ? base[1:0] ^ bt[1:0] : base[1:0] + bt[1:0];
            wa = {base[AW-1:2], lo};
            pend = (st == 2);
            if (st == 1)
                exp_rd = ref_mem[wa];
        end
        check(cycle_state, st[1:0]);
        if (st == 1)
            check({parity_io_out, data_io_out}, exp_rd);
        check(data_io_oe_n, st != 1 || output_enable_n);
        wd = 36'({$random(seed), $random(seed)});
        output_enable_n = 1'($random(seed));
        ctl.drive(sel, adv, we, hold, ln, a, wd, pend);
        {c_sel, c_adv, c_we, c_hold, c_ln, c_a, c_wd} = {sel, adv, we, hold, ln, a, wd};
        #1;
        check(parity_io_oe_n, st != 1 || output_enable_n);
    endtask
    // hang guard
    initial
    begin
        #100us;
        failures++;
        conclude();
    end
    initial
    begin
        seed = 78;
        {failures, comparisons, st, bt, pend} = 0;
        {c_sel, c_adv, c_we, c_hold, c_ln, c_a, c_wd} = {OFF, 3'h2, 4'hf, 40'h0};
        rst = 1;
        output_enable_n = 0;
        burst_mode = 1;
        repeat (20) @(posedge core_clk);
        #2;
        check({cycle_state, sleeping, data_io_oe_n, parity_io_oe_n}, 5'h03);
        rst = 0;
        // fill every word with full-lane bursts, all but the first started mid-block to show the wrap
        for (i = 0; i < 4; i++)
        begin
            step(ON, 0, 0, 0, 4'h0, AW'(i * 5));
            repeat (3) step(3'($random(seed)), 1, 1'($random(seed)), 0, 4'h0, '0);
        end
        // random traffic in both burst orders
        for (m = 0; m < 2; m++)
        begin
            step(OFF, 0, 1, 0, 4'h0, '0);
            @(posedge core_clk);
            #2 burst_mode = (m == 0);
            repeat (3) step(OFF, 1, 1, 0, 4'hf, '0);
            for (i = 0; i < 300; i++)
                step(($random(seed) % 4 != 0) ? ON : 3'($random(seed)), 1'($random(seed)),
                     1'($random(seed)), ($random(seed) % 8 == 0), 4'($random(seed)),
                     AW'($random(seed)));
        end
        // sleep: deselect first, a load while asleep must be ignored
        repeat (3) step(OFF, 0, 1, 0, 4'hf, '0);
        @(posedge core_clk);
        #2;
        ctl.sleep_pin(1);
        for (i = 0; i < 10 && sleeping !== 1'b1; i++)
            @(posedge core_clk);
        #2;
        check(sleeping, 1);
        ctl.drive(ON, 0, 1, 0, 4'h0, '0, 36'h0, 0);
        output_enable_n = 0;
        repeat (3) @(posedge core_clk);
        #2;
        check({cycle_state, data_io_oe_n}, 3'h1);
        ctl.drive(OFF, 0, 1, 0, 4'hf, '0, 36'h0, 0);
        ctl.sleep_pin(0);
        for (i = 0; i < 10 && sleeping !== 1'b0; i++)
            @(posedge core_clk);
        #2;
        check(sleeping, 0);
        repeat (2) step(OFF, 0, 1, 0, 4'hf, '0);
        repeat (20) step(ON, 1'($random(seed)), 1, 0, 4'hf, AW'($random(seed)));
        step(OFF, 0, 1, 0, 4'hf, '0);
        conclude();
    end
endmodule
